/* dv/elpi_lineunit.sv */
// Model of the external line interface unit feeding all transmit pins.
// Assumes the bench sets one launch edge for all ports, and bypass and loss per port.
`timescale 1ns/1ps
module elpi_lineunit (
   input wire launch_fall,
   input wire [15:0] bypass,
   input wire [15:0] los_n,
   output wire [15:0] tck,
   output wire [15:0] tpos,
   output wire [15:0] tneg
);
   reg ck = 1'b0;
   reg bit_q = 1'b0;
   // Free running line clock, 64 ns period, own phase
   initial #7 forever #32 ck = ~ck;
   // Data launched on the rising edge, or on the falling edge when launch_fall is set
   always @(posedge ck) if (!launch_fall) bit_q <= ~bit_q;
   always @(negedge ck) if (launch_fall) bit_q <= ~bit_q;
   assign tck = {16{ck}};
   assign tpos = {16{bit_q}} ^ 16'hA5C3;
   assign tneg = (bypass & los_n) | (~bypass & ~tpos);
endmodule

/* dv/elpi_props.sv */
// Checker of the line port top: bus answer, line clock, enables, forcing.
// Assumes binding to elpi_top; port 0 is never forced by the bench.
`timescale 1ns/1ps
module elpi_props #(parameter HALF_DIV = 61) (
   input wire ref_clk,
   input wire nrst,
   input wire pready,
   input wire pslverr,
   input wire [15:0] rx_force_zero_in,
   input wire [15:0] tx_line_clock_in,
   input wire [15:0] rx_line_clock_out,
   input wire [15:0] rx_line_clock_oe,
   input wire [15:0] rx_pos_rail_or_nrz_out,
   input wire [15:0] rx_pos_oe,
   input wire [15:0] rx_neg_rail_out,
   input wire [15:0] rx_neg_oe,
   input wire [15:0] tx_strobe_out
);
   // ----------------------------------------
   // Helpers and assertions
   // ----------------------------------------
   reg [7:0] cnt_q;
   reg seen_q;
   reg last_q;
   reg [7:0] hist_q;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Half period count of port 0 clock, tx clock pin history
   always @(posedge ref_clk) begin
      last_q <= rx_line_clock_out[0];
      hist_q <= {hist_q[6:0], tx_line_clock_in[0]};
      if (!nrst || !rx_line_clock_oe[0]) begin
         cnt_q <= 8'h00;
         seen_q <= 1'b0;
      end else if (rx_line_clock_out[0] != last_q) begin
         cnt_q <= 8'h01;
         seen_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
   chk_clk_half_period: assert property (seen_q && $changed(rx_line_clock_out[0]) |-> int'(cnt_q) == HALF_DIV)
      else $error("line clock half period wrong");
   chk_data_after_edge: assert property ($changed(rx_pos_rail_or_nrz_out[0]) && rx_pos_oe[0] && $past(rx_pos_oe[0])
      |-> $past(rx_line_clock_out[0]) != $past(rx_line_clock_out[0], 2))
      else $error("rx data moved without clock edge");
   chk_clk_oe_tie: assert property ((rx_line_clock_oe & ~rx_pos_oe) == 16'h0000)
      else $error("clock driven while data floats");
   chk_neg_oe_tie: assert property ((rx_neg_oe & ~rx_pos_oe) == 16'h0000)
      else $error("neg data driven alone");
   chk_force_zero: assert property (((rx_pos_rail_or_nrz_out | rx_neg_rail_out | ~rx_pos_oe | ~rx_neg_oe)
      & $past(rx_force_zero_in, 3) & $past(rx_force_zero_in, 4)) == 16'h0000)
      else $error("forced port not driven low");
   chk_tx_strobe_cause: assert property (tx_strobe_out[0] |-> hist_q != 8'h00 && hist_q != 8'hFF)
      else $error("tx strobe without pin clock edge");
   chk_pready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
endmodule
bind elpi_top elpi_props #(.HALF_DIV(HALF_DIV)) u_props (.ref_clk(ref_clk), .nrst(nrst), .pready(pready),
   .pslverr(pslverr), .rx_force_zero_in(rx_force_zero_in), .tx_line_clock_in(tx_line_clock_in),
   .rx_line_clock_out(rx_line_clock_out), .rx_line_clock_oe(rx_line_clock_oe),
   .rx_pos_rail_or_nrz_out(rx_pos_rail_or_nrz_out), .rx_pos_oe(rx_pos_oe),
   .rx_neg_rail_out(rx_neg_rail_out), .rx_neg_oe(rx_neg_oe), .tx_strobe_out(tx_strobe_out));

/* dv/elpi_top_test.sv */
// Self-checking bench of the sixteen-port line interface over APB.
// Assumes the bound checker and the line unit model beside the design.
`timescale 1ns/1ps
`define CK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module elpi_top_test;
   // ----------------------------------------
   // Stimulus, design and line unit
   // ----------------------------------------
   reg ref_clk = 1'b0;
   reg nrst = 1'b0;
   reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, launch_fall = 1'b0, er;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0000_0000, rd;
   reg [15:0] rx_pos_data = 16'h0000, rx_neg_data = 16'hFFFF, frc = 16'h0000, byp = 16'h0000, los_n = 16'hFFFF;
   reg [3:0] dcnt = 4'h0;
   wire [31:0] prdata;
   wire pready, pslverr, irq_q;
   wire [15:0] tck, tpos, tneg, rco, rco_oe, rpo, rpo_oe, rno, rno_oe, tpo, tno, tstb;
   int err_total = 0, checks_done = 0, g;
   always #2 ref_clk = ~ref_clk;
   // Receive data that alternates at each launch
   always @(posedge ref_clk) begin
      dcnt <= dcnt + 4'h1;
      rx_pos_data <= {16{dcnt[2]}};
      rx_neg_data <= {16{~dcnt[2]}};
   end
   elpi_top #(.HALF_DIV(2)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_q(irq_q), .rx_pos_data(rx_pos_data), .rx_neg_data(rx_neg_data), .rx_force_zero_in(frc),
      .tx_line_clock_in(tck), .tx_pos_rail_or_nrz_in(tpos), .tx_neg_rail_or_los_in(tneg),
      .rx_line_clock_out(rco), .rx_line_clock_oe(rco_oe), .rx_pos_rail_or_nrz_out(rpo), .rx_pos_oe(rpo_oe),
      .rx_neg_rail_out(rno), .rx_neg_oe(rno_oe), .tx_pos_out(tpo), .tx_neg_out(tno), .tx_strobe_out(tstb));
   elpi_lineunit u_lu (.launch_fall(launch_fall), .bypass(byp), .los_n(los_n), .tck(tck), .tpos(tpos),
      .tneg(tneg));
   // One APB transfer, released after pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      if (i == 50) begin err_total++; results(); end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CK("read data", e, rd)
   endtask
   // Wait for receive data change, then look at its clock
   task automatic edge_chk(input int p, input logic e);
      logic prev;
      int i;
      @(posedge ref_clk);
      #1 prev = rpo[p];
      for (i = 0; i < 40; i++) begin
         @(posedge ref_clk);
         #1;
         if (rpo[p] !== prev) break;
      end
      if (i == 40) begin err_total++; results(); end
      `CK("rx clock at data change", e, rco[p])
   endtask
   task automatic wstb(input int p);
      int i;
      for (i = 0; i < 80; i++) begin
         @(posedge ref_clk);
         #1;
         if (tstb[p] === 1'b1) break;
      end
      if (i == 80) begin err_total++; results(); end
   endtask
   // Sampled tx data and the pin clock level at the strobe
   task automatic tx_chk(input int p, input logic e);
      wstb(p);
      `CK("tx clock level", e, tck[p])
      `CK("tx pos", tpos[p], tpo[p])
      `CK("tx neg", byp[p] ? 1'b0 : tneg[p], tno[p])
   endtask
   task automatic results;
      if (err_total == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      nrst <= 1'b1;
      `CK("oe after reset", 16'h0000, rpo_oe | rco_oe | rno_oe)
      for (g = 0; g < 5; g++) if (g != 3) rchk(12'(g * 4), 32'h0000_0000);
      apb(1'b1, 12'h014, 32'h0000_FFFF);
      rchk(12'h014, 32'h0000_0000);
      apb(1'b0, 12'h01C, 32'h0000_0000);
      `CK("unmapped data", 32'h0000_0000, rd)
      `CK("unmapped error", 1'b1, er)
      byp = 16'h00F0;
      apb(1'b1, 12'h004, {16'h0000, byp});
      apb(1'b1, 12'h008, 32'h0000_7FFF);
      rchk(12'h004, 32'h0000_00F0);
      rchk(12'h008, 32'h0000_7FFF);
      `CK("clock oe", 16'h7FFF, rco_oe)
      `CK("pos oe", 16'h7FFF, rpo_oe)
      `CK("neg oe", 16'h7F0F, rno_oe)
      for (g = 0; g < 2; g++) begin
         apb(1'b1, 12'h000, g);
         edge_chk(0, !g);
         `CK("rx neg rail", ~rpo[0], rno[0])
         edge_chk(4, 1'b1);
      end
      for (g = 0; g < 2; g++) begin
         launch_fall <= g[0];
         apb(1'b1, 12'h000, g ? 32'h0000_0010 : 32'h0000_0000);
         tx_chk(0, g[0]);
         tx_chk(4, 1'b0);
      end
      @(posedge ref_clk);
      frc <= 16'h8100;
      repeat (6) @(posedge ref_clk);
      #1;
      `CK("forced data", 16'h0000, (rpo | rno) & 16'h8100)
      `CK("forced oe", 16'h8100, rpo_oe & rno_oe & 16'h8100)
      rchk(12'h018, 32'h0000_8100);
      frc <= 16'h0000;
      apb(1'b1, 12'h010, 32'h0000_0020);
      los_n[5] <= 1'b0;
      wstb(5);
      wstb(5);
      repeat (3) @(posedge ref_clk);
      #1;
      `CK("irq on loss", 1'b1, irq_q)
      rchk(12'h00C, 32'h0000_0020);
      rchk(12'h014, 32'h0000_0020);
      apb(1'b1, 12'h00C, 32'h0000_0020);
      rchk(12'h00C, 32'h0000_0000);
      `CK("irq cleared", 1'b0, irq_q)
      apb(1'b1, 12'h010, 32'h0000_0000);
      los_n[5] <= 1'b1;
      wstb(5);
      wstb(5);
      los_n[5] <= 1'b0;
      wstb(5);
      wstb(5);
      rchk(12'h00C, 32'h0000_0020);
      `CK("irq masked", 1'b0, irq_q)
      results();
   end
endmodule

/* shared/elpi_defs.vh */
// Constants of the sixteen-port E1 line port interface: register map, fields, timing.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef ELPI_DEFS_VH
`define ELPI_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses, APB)
// ----------------------------------------------------------------
`define ELPI_OFF_GRP_CLK    12'h000
`define ELPI_OFF_BYPASS     12'h004
`define ELPI_OFF_RX_EN      12'h008
`define ELPI_OFF_INT_STAT   12'h00C
`define ELPI_OFF_INT_MASK   12'h010
`define ELPI_OFF_TX_LOS     12'h014
`define ELPI_OFF_FORCE_ZERO 12'h018

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define ELPI_GRP_RX_INV_LSB 0
`define ELPI_GRP_TX_INV_LSB 4
`define ELPI_RST_GRP_CLK 8'h00
`define ELPI_RST_BYPASS 16'h0000
`define ELPI_RST_RX_EN 16'h0000
`define ELPI_RST_MASK 16'h0000

// ----------------------------------------------------------------
// Timing: system clock 250 MHz, line clock 2.048 MHz
// ----------------------------------------------------------------
`define ELPI_SYS_CLK_KHZ 250000
`define ELPI_LINE_CLK_KHZ 2048
// Half line period in system cycles, rounded down, 61 at these clocks
`define ELPI_HALF_DIV ((`ELPI_SYS_CLK_KHZ / `ELPI_LINE_CLK_KHZ) / 2)

`endif

/* verilog/elpi_port.v */
// One E1 line port: receive clock and data output, transmit sampling.
// Assumes a shared line-clock phase from the top and raw pins synchronised here.
`timescale 1ns/1ps
`include "elpi_defs.vh"

module elpi_port (
   input wire ref_clk,
   input wire nrst,
   input wire rclk_rise,
   input wire rclk_fall,
   input wire rclk_lvl,
   input wire rx_inv,
   input wire tx_inv,
   input wire bypass,
   input wire rx_en,
   input wire rx_force_zero_in,
   input wire rx_pos_data,
   input wire rx_neg_data,
   input wire tx_line_clock_in,
   input wire tx_pos_rail_or_nrz_in,
   input wire tx_neg_rail_or_los_in,
   output reg rx_line_clock_out,
   output reg rx_line_clock_oe,
   output reg rx_pos_rail_or_nrz_out,
   output reg rx_pos_oe,
   output reg rx_neg_rail_out,
   output reg rx_neg_oe,
   output reg tx_pos_q,
   output reg tx_neg_q,
   output reg tx_strobe_q,
   output reg tx_los_q
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   reg [2:0] s1_q;
   reg [2:0] s2_q;
   reg s1_qz;
   reg s2_qz;
   reg tclk_prev_q;
   reg pos_q;
   reg neg_q;
   wire tclk_s;
   wire tx_edge;

   // Two flops on every pin
   always @(posedge ref_clk) begin
      if (!nrst) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
         s1_qz <= 1'b0;
         s2_qz <= 1'b0;
      end else begin
         s1_q <= {tx_line_clock_in, tx_pos_rail_or_nrz_in, tx_neg_rail_or_los_in};
         s2_q <= s1_q;
         s1_qz <= rx_force_zero_in;
         s2_qz <= s1_qz;
      end
   end

   assign tclk_s = s2_q[2];
   // Falling by default, rising when inverted
   assign tx_edge = tx_inv ? (tclk_s & ~tclk_prev_q) : (~tclk_s & tclk_prev_q);

   // ----------------------------------------------------------------
   // Transmit sampling
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (!nrst) begin
         tclk_prev_q <= 1'b0;
         tx_pos_q <= 1'b0;
         tx_neg_q <= 1'b0;
         tx_strobe_q <= 1'b0;
         tx_los_q <= 1'b0;
      end else begin
         tclk_prev_q <= tclk_s;
         tx_strobe_q <= tx_edge;
         if (tx_edge) begin
            tx_pos_q <= s2_q[1];
            tx_neg_q <= bypass ? 1'b0 : s2_q[0];
            tx_los_q <= bypass & ~s2_q[0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Receive output launch
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (!nrst) begin
         pos_q <= 1'b0;
         neg_q <= 1'b0;
      end else if (rx_inv ? rclk_fall : rclk_rise) begin
         pos_q <= rx_pos_data;
         neg_q <= rx_neg_data;
      end
   end

   // Pin drive with enables and force-zero
   always @(posedge ref_clk) begin
      if (!nrst) begin
         rx_line_clock_out <= 1'b0;
         rx_line_clock_oe <= 1'b0;
         rx_pos_rail_or_nrz_out <= 1'b0;
         rx_pos_oe <= 1'b0;
         rx_neg_rail_out <= 1'b0;
         rx_neg_oe <= 1'b0;
      end else begin
         rx_line_clock_out <= rclk_lvl;
         rx_line_clock_oe <= rx_en;
         rx_pos_rail_or_nrz_out <= s2_qz ? 1'b0 : pos_q;
         rx_pos_oe <= rx_en | s2_qz;
         rx_neg_rail_out <= s2_qz ? 1'b0 : neg_q;
         rx_neg_oe <= s2_qz | (rx_en & ~bypass);
      end
   end

endmodule

/* verilog/elpi_top.v */
// Sixteen-port E1 line interface: four groups of four ports, APB registers, interrupt.
// Assumes an APB master on ref_clk and line pins from an external line interface unit.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "elpi_defs.vh"

// Contract
// - Four groups of four, sixteen ports
// - Drive 2.048 MHz receive clock out
// - Receive data changes rising, falling if inverted
// - Enable zero tristates clock and pos data; pos is still driven while force-zero is active
// - Bypass selects rail or NRZ on pos
// - Neg output tristated on bypass or disable; it is still driven while force-zero is active
// - Sample transmit falling, rising if inverted
// - Pos input rail or NRZ per bypass
// - Neg input rail, or active-low loss
// - Force-zero input drives receive data low
module elpi_top #(
   parameter NUM_GROUPS = 4,
   parameter PORTS_PER_GROUP = 4,
   parameter HALF_DIV = `ELPI_HALF_DIV
) (
   input wire ref_clk,
   input wire nrst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg irq_q,
   input wire [15:0] rx_pos_data,
   input wire [15:0] rx_neg_data,
   input wire [15:0] rx_force_zero_in,
   input wire [15:0] tx_line_clock_in,
   input wire [15:0] tx_pos_rail_or_nrz_in,
   input wire [15:0] tx_neg_rail_or_los_in,
   output wire [15:0] rx_line_clock_out,
   output wire [15:0] rx_line_clock_oe,
   output wire [15:0] rx_pos_rail_or_nrz_out,
   output wire [15:0] rx_pos_oe,
   output wire [15:0] rx_neg_rail_out,
   output wire [15:0] rx_neg_oe,
   output wire [15:0] tx_pos_out,
   output wire [15:0] tx_neg_out,
   output wire [15:0] tx_strobe_out
);

   localparam NP = NUM_GROUPS * PORTS_PER_GROUP;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg [3:0] rx_clock_invert_bit_q;
   reg [3:0] tx_clock_invert_bit_q;
   reg [15:0] nrz_bypass_bit_q;
   reg [15:0] rx_output_enable_bit_q;
   reg [15:0] int_stat_q;
   reg [15:0] int_mask_q;
   reg [15:0] los_prev_q;
   reg [7:0] div_q;
   reg rclk_q;
   reg rclk_rise_q;
   reg rclk_fall_q;
   wire [15:0] tx_los;
   wire [15:0] los_set;
   wire wr_en;
   wire rd_en;
   reg [31:0] rd_d;
   reg hit_d;
   reg [15:0] frc_s1_q;
   reg [15:0] frc_s2_q;

   assign wr_en = psel & penable & pwrite & ~pready;
   assign rd_en = psel & penable & ~pwrite & ~pready;

   // ----------------------------------------------------------------
   // Free-running line clock generator
   // ----------------------------------------------------------------
   // One divider feeds every receive clock output
   always @(posedge ref_clk) begin
      if (!nrst) begin
         div_q <= 8'h00;
         rclk_q <= 1'b0;
         rclk_rise_q <= 1'b0;
         rclk_fall_q <= 1'b0;
      end else if (div_q == HALF_DIV - 1) begin
         div_q <= 8'h00;
         rclk_q <= ~rclk_q;
         rclk_rise_q <= ~rclk_q;
         rclk_fall_q <= rclk_q;
      end else begin
         div_q <= div_q + 8'h01;
         rclk_rise_q <= 1'b0;
         rclk_fall_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Port array
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi = gi + 1) begin : g_port
         elpi_port u_port (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .rclk_rise(rclk_rise_q),
            .rclk_fall(rclk_fall_q),
            .rclk_lvl(rclk_q),
            .rx_inv(rx_clock_invert_bit_q[gi / PORTS_PER_GROUP]),
            .tx_inv(tx_clock_invert_bit_q[gi / PORTS_PER_GROUP]),
            .bypass(nrz_bypass_bit_q[gi]),
            .rx_en(rx_output_enable_bit_q[gi]),
            .rx_force_zero_in(rx_force_zero_in[gi]),
            .rx_pos_data(rx_pos_data[gi]),
            .rx_neg_data(rx_neg_data[gi]),
            .tx_line_clock_in(tx_line_clock_in[gi]),
            .tx_pos_rail_or_nrz_in(tx_pos_rail_or_nrz_in[gi]),
            .tx_neg_rail_or_los_in(tx_neg_rail_or_los_in[gi]),
            .rx_line_clock_out(rx_line_clock_out[gi]),
            .rx_line_clock_oe(rx_line_clock_oe[gi]),
            .rx_pos_rail_or_nrz_out(rx_pos_rail_or_nrz_out[gi]),
            .rx_pos_oe(rx_pos_oe[gi]),
            .rx_neg_rail_out(rx_neg_rail_out[gi]),
            .rx_neg_oe(rx_neg_oe[gi]),
            .tx_pos_q(tx_pos_out[gi]),
            .tx_neg_q(tx_neg_out[gi]),
            .tx_strobe_q(tx_strobe_out[gi]),
            .tx_los_q(tx_los[gi])
         );
      end
   endgenerate

   // New loss of signal on any port
   assign los_set = tx_los & ~los_prev_q;

   // Two flops on the force-zero pins before the status read
   always @(posedge ref_clk) begin
      if (!nrst) begin
         frc_s1_q <= 16'h0000;
         frc_s2_q <= 16'h0000;
      end else begin
         frc_s1_q <= rx_force_zero_in;
         frc_s2_q <= frc_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // Register writes and sticky status
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (!nrst) begin
         rx_clock_invert_bit_q <= 4'h0;
         tx_clock_invert_bit_q <= 4'h0;
         nrz_bypass_bit_q <= `ELPI_RST_BYPASS;
         rx_output_enable_bit_q <= `ELPI_RST_RX_EN;
         int_mask_q <= `ELPI_RST_MASK;
         int_stat_q <= 16'h0000;
         los_prev_q <= 16'h0000;
      end else begin
         los_prev_q <= tx_los;
         if (wr_en && paddr == `ELPI_OFF_GRP_CLK) begin
            rx_clock_invert_bit_q <= pwdata[`ELPI_GRP_RX_INV_LSB +: 4];
            tx_clock_invert_bit_q <= pwdata[`ELPI_GRP_TX_INV_LSB +: 4];
         end
         if (wr_en && paddr == `ELPI_OFF_BYPASS) begin
            nrz_bypass_bit_q <= pwdata[15:0];
         end
         if (wr_en && paddr == `ELPI_OFF_RX_EN) begin
            rx_output_enable_bit_q <= pwdata[15:0];
         end
         if (wr_en && paddr == `ELPI_OFF_INT_MASK) begin
            int_mask_q <= pwdata[15:0];
         end
         // Set wins over write-one-to-clear
         if (wr_en && paddr == `ELPI_OFF_INT_STAT) begin
            int_stat_q <= (int_stat_q & ~pwdata[15:0]) | los_set;
         end else begin
            int_stat_q <= int_stat_q | los_set;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   always @* begin
      rd_d = 32'h0000_0000;
      hit_d = 1'b1;
      case (paddr)
         `ELPI_OFF_GRP_CLK: rd_d = {24'h00_0000, tx_clock_invert_bit_q, rx_clock_invert_bit_q};
         `ELPI_OFF_BYPASS: rd_d = {16'h0000, nrz_bypass_bit_q};
         `ELPI_OFF_RX_EN: rd_d = {16'h0000, rx_output_enable_bit_q};
         `ELPI_OFF_INT_STAT: rd_d = {16'h0000, int_stat_q};
         `ELPI_OFF_INT_MASK: rd_d = {16'h0000, int_mask_q};
         `ELPI_OFF_TX_LOS: rd_d = {16'h0000, tx_los};
         `ELPI_OFF_FORCE_ZERO: rd_d = {16'h0000, frc_s2_q};
         default: hit_d = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // APB answer and interrupt
   // ----------------------------------------------------------------
   // One wait state: pready rises on the second access cycle
   always @(posedge ref_clk) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(int_stat_q & int_mask_q);
         if (wr_en || rd_en) begin
            pready <= 1'b1;
            pslverr <= ~hit_d;
            prdata <= rd_en ? rd_d : 32'h0000_0000;
         end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

endmodule
